/* File: dlh_defines.vh */
`ifndef DLH_DEFINES_VH
`define DLH_DEFINES_VH

// Serial clock is the VCO clock divided by this figure.
`define DLH_SER_DIV      8
`define DLH_DIV_W        3

// All counts below are in serial clock cycles.
`define DLH_CNT_W        8
`define DLH_ACK_LOW      8'h10
`define DLH_ACK_MIN      8'h20
`define DLH_SYNC_REQ     8'h80
`define DLH_SYNC_DLY     8'h10
`define DLH_SYNC_LOW     8'h80

// Read data word width.
`define DLH_WORD_W       16

`endif

/* File: dlh_debug_link.v */
// Function
// - Serial clock is VCO clock divided by eight.
// - Acknowledge is 16 cycles low, then speedup.
// - Acknowledge starts 32 cycles after command end.
// - No upper bound on acknowledge delay.
// - Wait or stop discards pending command and pulses abort.
// - Byte read fetches data before acknowledging.
// - Reads return a word; host picks byte.
// - Device itself makes acknowledge falling edge.
// - No nested acknowledges; host aborts first.
// - Long low pulse runs timing reference, aborts.
// - Firmware access continues, acknowledge still suppressed.
// - Resume commands continue; only acknowledge cancelled.
// - Short low pulse aborts on falling edge.
// - Next falling edge after abort starts command.
// - Acknowledge off at reset; on/off commands.
// - Bits start on host edge, sixteen cycles.
// - Reference reply: wait 16, low 128, speedup.
`include "dlh_defines.vh"

module dlh_debug_link #(
    parameter DIV_W    = `DLH_DIV_W,
    parameter CNT_W    = `DLH_CNT_W,
    parameter WORD_W   = `DLH_WORD_W,
    parameter [CNT_W-1:0] ACK_LOW  = `DLH_ACK_LOW,
    parameter [CNT_W-1:0] ACK_MIN  = `DLH_ACK_MIN,
    parameter [CNT_W-1:0] SYNC_REQ = `DLH_SYNC_REQ,
    parameter [CNT_W-1:0] SYNC_DLY = `DLH_SYNC_DLY,
    parameter [CNT_W-1:0] SYNC_LOW = `DLH_SYNC_LOW
) (
    // Clock (the VCO clock) and reset
    input  wire              sys_clk,
    input  wire              rst_n,
    // Debug serial pin, open drain with speedup
    input  wire              debug_serial_pin_in,
    output reg               debug_serial_pin_out,
    output reg               debug_serial_pin_oe_n,
    // Decoded command from the debug module receiver
    input  wire              cmd_end,
    input  wire              cmd_read,
    input  wire              cmd_fw,
    input  wire              cmd_go,
    input  wire              cmd_ack_on,
    input  wire              cmd_ack_off,
    // Execution status from the CPU side
    input  wire              exec_done,
    input  wire              cpu_wait_stop,
    // Bus cycle for hardware reads
    output wire              bus_req,
    input  wire              bus_ack,
    input  wire [WORD_W-1:0] bus_rdata,
    // Status toward the debug module
    output reg  [WORD_W-1:0] read_word,
    output reg               ack_enabled,
    output reg               bit_start,
    output reg               cmd_abort,
    output reg               ack_sent,
    output reg               sync_done
);

    // One-hot state codes; an illegal code falls back to idle.
    localparam [8:0] ST_IDLE   = 9'h001;
    localparam [8:0] ST_PEND   = 9'h002;
    localparam [8:0] ST_ACK_LO = 9'h004;
    localparam [8:0] ST_ACK_HI = 9'h008;
    localparam [8:0] ST_LOW    = 9'h010;
    localparam [8:0] ST_WAIT   = 9'h020;
    localparam [8:0] ST_DLY    = 9'h040;
    localparam [8:0] ST_DRV    = 9'h080;
    localparam [8:0] ST_SPD    = 9'h100;

    // The divider wraps at this count, giving one tick per serial clock.
    localparam integer          DIV_LAST_I = `DLH_SER_DIV - 1;
    localparam [DIV_W-1:0]      DIV_LAST   = DIV_LAST_I[DIV_W-1:0];
    localparam [DIV_W-1:0]      DIV_ONE    = {{(DIV_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0]      CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};

    reg  [8:0]       st_q;
    reg  [8:0]       st_d;
    reg  [DIV_W-1:0] div_q;
    reg  [CNT_W-1:0] cnt_q;
    reg              pin_s1_q;
    reg              pin_s2_q;
    reg              pin_s3_q;
    reg              rd_q;
    reg              fw_q;
    reg              go_q;
    reg              done_q;
    reg              done_now;
    wire             tick;
    wire             driving;
    wire             fall;
    wire             take_cmd;

    // Saturating increment keeps long host low pulses from wrapping.
    function [CNT_W-1:0] sat_inc;
        input [CNT_W-1:0] v;
        begin
            sat_inc = (&v) ? v : v + CNT_ONE;
        end
    endfunction

    // Last tick of a phase lasting n serial cycles.
    function last_tick;
        input [CNT_W-1:0] c;
        input [CNT_W-1:0] n;
        input             t;
        begin
            last_tick = t && (c == n - CNT_ONE);
        end
    endfunction

    // The pin is ours in both acknowledge phases and in the reference low and speedup phases, not during the delay.
    function drives_pin;
        input [8:0] s;
        begin
            drives_pin = (s == ST_ACK_LO) || (s == ST_ACK_HI)
                         || (s == ST_DRV) || (s == ST_SPD);
        end
    endfunction

    // Only the one-tick speedup phases drive the pin high.
    function drives_high;
        input [8:0] s;
        begin
            drives_high = (s == ST_ACK_HI) || (s == ST_SPD);
        end
    endfunction

    assign tick     = (div_q == DIV_LAST);
    assign driving  = ~debug_serial_pin_oe_n;
    // Our own low drive must not look like a host edge.
    assign fall     = pin_s3_q & ~pin_s2_q & ~driving;
    // Held only until data arrives, so each read fetches once.
    assign bus_req  = (st_q == ST_PEND) & rd_q & ~done_q;
    // Commands are taken only in idle, so acknowledges cannot nest.
    assign take_cmd = (st_q == ST_IDLE) & cmd_end & ~fall;

    always @* begin
        done_now = done_q | (rd_q ? bus_ack : exec_done);
    end

    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                // A host edge outranks a command end in the same cycle.
                if (fall) begin
                    st_d = ST_LOW;
                end else if (cmd_end && !cmd_ack_off) begin
                    st_d = ST_PEND;
                end
            end
            ST_PEND: begin
                if (fall) begin
                    st_d = ST_LOW;
                end else if (cpu_wait_stop && !done_q) begin
                    // Stop or wait discards only work not yet done.
                    st_d = ST_IDLE;
                end else if (done_q && cnt_q >= ACK_MIN) begin
                    // The wait here may be arbitrarily long.
                    st_d = ack_enabled ? ST_ACK_LO : ST_IDLE;
                end
            end
            ST_ACK_LO: begin
                // The first tick is partial, so this may run one tick short.
                if (last_tick(cnt_q, ACK_LOW, tick)) begin
                    st_d = ST_ACK_HI;
                end
            end
            ST_ACK_HI: begin
                // Release at the next tick, so the speedup lasts one tick.
                if (tick) begin
                    st_d = ST_IDLE;
                end
            end
            ST_LOW: begin
                // Released early, this was a bit start or a short abort.
                if (pin_s2_q) begin
                    st_d = ST_IDLE;
                end else if (cnt_q >= SYNC_REQ) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // The host may still hold the pin low; wait for high.
                if (pin_s2_q) begin
                    st_d = ST_DLY;
                end
            end
            ST_DLY: begin
                // Leave the host time to drop its speedup before we drive.
                if (last_tick(cnt_q, SYNC_DLY, tick)) begin
                    st_d = ST_DRV;
                end
            end
            ST_DRV: begin
                // The reference low phase is timed at our own serial rate.
                if (last_tick(cnt_q, SYNC_LOW, tick)) begin
                    st_d = ST_SPD;
                end
            end
            ST_SPD: begin
                if (tick) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q                  <= ST_IDLE;
            div_q                 <= {DIV_W{1'b0}};
            cnt_q                 <= {CNT_W{1'b0}};
            // Starting at the idle high level avoids a false edge after reset.
            pin_s1_q              <= 1'b1;
            pin_s2_q              <= 1'b1;
            pin_s3_q              <= 1'b1;
            rd_q                  <= 1'b0;
            fw_q                  <= 1'b0;
            go_q                  <= 1'b0;
            done_q                <= 1'b0;
            read_word             <= {WORD_W{1'b0}};
            ack_enabled           <= 1'b0;
            bit_start             <= 1'b0;
            cmd_abort             <= 1'b0;
            ack_sent              <= 1'b0;
            sync_done             <= 1'b0;
            debug_serial_pin_out  <= 1'b0;
            debug_serial_pin_oe_n <= 1'b1;
        end else begin
            // Two stages tame the asynchronous pin; the third forms the edge.
            pin_s1_q  <= debug_serial_pin_in;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            st_q      <= st_d;
            bit_start <= 1'b0;
            cmd_abort <= 1'b0;
            // Completion pulses come with the release of the pin.
            ack_sent  <= (st_q == ST_ACK_HI) && (st_d == ST_IDLE);
            sync_done <= (st_q == ST_SPD) && (st_d == ST_IDLE);
            // Bit time is measured from the perceived host edge.
            div_q <= (fall || tick) ? {DIV_W{1'b0}}
                                    : div_q + DIV_ONE;
            // Each phase is timed from its own start.
            if (st_d != st_q) begin
                cnt_q <= {CNT_W{1'b0}};
            end else if (tick) begin
                cnt_q <= sat_inc(cnt_q);
            end
            // A host edge in idle opens a new bit or command.
            if (st_q == ST_IDLE && fall) begin
                bit_start <= 1'b1;
            end
            if (take_cmd) begin
                rd_q   <= cmd_read;
                fw_q   <= cmd_fw;
                go_q   <= cmd_go;
                // The enable command counts as done at once; its acknowledge still waits for ACK_MIN.
                done_q <= cmd_ack_on;
                if (cmd_ack_on) begin
                    ack_enabled <= 1'b1;
                end
                if (cmd_ack_off) begin
                    ack_enabled <= 1'b0;
                end
            end
            if (st_q == ST_PEND) begin
                if (bus_req && bus_ack) begin
                    // The whole word is kept; choosing the byte is the host's.
                    read_word <= bus_rdata;
                end
                done_q <= done_now;
                if (fall) begin
                    // Firmware and resume work runs on; only the
                    // acknowledge is dropped.
                    cmd_abort <= ~fw_q & ~go_q;
                end else if (cpu_wait_stop && !done_q) begin
                    cmd_abort <= 1'b1;
                end
            end
            if (st_d == ST_WAIT && st_q == ST_LOW) begin
                cmd_abort <= 1'b1;
            end
            // Leaving the pending state forgets any completion seen.
            if (st_d != ST_PEND) begin
                done_q <= 1'b0;
            end
            // The device owns the acknowledge falling edge.
            debug_serial_pin_oe_n <= ~drives_pin(st_d);
            debug_serial_pin_out  <= drives_high(st_d);
        end
    end

endmodule

/* File: dlh_link_monitor.sv */
module dlh_link_monitor #(
    parameter WORD_W = 16
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              debug_serial_pin_out,
    input wire logic              debug_serial_pin_oe_n,
    input wire logic              cmd_end,
    input wire logic              cmd_ack_on,
    input wire logic              bus_req,
    input wire logic              bus_ack,
    input wire logic [WORD_W-1:0] bus_rdata,
    input wire logic [WORD_W-1:0] read_word,
    input wire logic              ack_enabled,
    input wire logic              cmd_abort,
    input wire logic              ack_sent,
    input wire logic              sync_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] since_q;
    logic [10:0] low_q;
    wire drv_low = !debug_serial_pin_oe_n && !debug_serial_pin_out;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Both counters saturate or restart, so long idle spans cannot wrap.
    always @(posedge sys_clk) begin
        if (!rst_n || cmd_end) since_q <= {10'h0, !rst_n} * 11'h7ff;
        else if (~&since_q) since_q <= since_q + 11'h1;
        low_q <= drv_low ? low_q + 11'h1 : 11'h0;
    end
    a_reset_idle: assert property (disable iff (1'b0)
        !rst_n |=> debug_serial_pin_oe_n && !debug_serial_pin_out
        && !ack_enabled) else $error("pin driven after reset");
    a_ack_min_gap: assert property (
        $fell(debug_serial_pin_oe_n) |-> since_q >= 11'd248)
        else $error("acknowledge began too soon");
    a_low_length: assert property (
        $rose(debug_serial_pin_out) |-> low_q inside {[113:128], [1009:1024]})
        else $error("low phase has wrong length");
    a_speedup_tick: assert property (
        $rose(debug_serial_pin_out) |-> (debug_serial_pin_out
        && !debug_serial_pin_oe_n)[*8] ##1 (debug_serial_pin_oe_n
        && !debug_serial_pin_out)) else $error("speedup not one tick");
    a_high_driven: assert property (
        debug_serial_pin_out |-> !debug_serial_pin_oe_n)
        else $error("high level set while released");
    a_done_pulse: assert property (
        $rose(debug_serial_pin_oe_n) |-> ##[0:1] (ack_sent || sync_done))
        else $error("release without completion pulse");
    a_abort_quiet: assert property (
        cmd_abort |-> debug_serial_pin_oe_n && !ack_sent)
        else $error("abort while driving");
    a_read_capture: assert property (
        bus_ack && bus_req |=> read_word == $past(bus_rdata))
        else $error("read word not captured");
    a_enable_cause: assert property (
        $rose(ack_enabled) |-> $past(cmd_end && cmd_ack_on))
        else $error("enable rose without its command");
endmodule

bind dlh_debug_link dlh_link_monitor #(.WORD_W(WORD_W)) dlh_link_monitor_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd_end(cmd_end),
    .debug_serial_pin_out(debug_serial_pin_out), .bus_req(bus_req),
    .debug_serial_pin_oe_n(debug_serial_pin_oe_n), .bus_ack(bus_ack),
    .cmd_ack_on(cmd_ack_on), .bus_rdata(bus_rdata), .read_word(read_word),
    .ack_enabled(ack_enabled), .cmd_abort(cmd_abort), .ack_sent(ack_sent),
    .sync_done(sync_done));

/* File: dlh_host_model.sv */
module dlh_host_model (
    input  wire logic dev_out,
    input  wire logic dev_oe_n,
    output wire logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_low = 1'b0;
    // Released pin sits at the pull-up; the host speedup adds nothing to it.
    assign pin_level = !dev_oe_n ? dev_out : !host_low;
    // Low for the given serial ticks, then a one-tick speedup.
    // Edges land 1 ns after a clock edge, never on it.
    task automatic low_pulse(input int ticks);
        #1;
        host_low = 1'b1;
        #(ticks * 32);
        host_low = 1'b0;
        #32;
    endtask
endmodule

/* File: testbench.sv */
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, pin, cmd_end = 0, cmd_read = 0, cmd_fw = 0;
    logic cmd_go = 0, cmd_ack_on = 0, cmd_ack_off = 0, exec_done = 0;
    logic cpu_wait_stop = 0, bus_ack = 0, out, oe_n, bus_req, ack_enabled;
    logic bit_start, cmd_abort, ack_sent, sync_done, saw_bit = 0;
    logic [15:0] bus_rdata = 16'h0, read_word, d;
    logic [19:0] q[$];
    logic [19:0] e;
    int errors = 0, checks_done = 0;
    localparam logic [19:0] ACK = 20'h40000, SYN = 20'h20000, ABT = 20'h10000;
    always #2 sys_clk = ~sys_clk;
    dlh_host_model dlh_host_model_inst (.dev_out(out), .dev_oe_n(oe_n),
        .pin_level(pin));
    dlh_debug_link dlh_debug_link_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .debug_serial_pin_in(pin), .debug_serial_pin_out(out),
        .debug_serial_pin_oe_n(oe_n), .cmd_end(cmd_end), .cmd_read(cmd_read),
        .cmd_fw(cmd_fw), .cmd_go(cmd_go), .cmd_ack_on(cmd_ack_on),
        .cmd_ack_off(cmd_ack_off), .exec_done(exec_done),
        .cpu_wait_stop(cpu_wait_stop), .bus_req(bus_req), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .read_word(read_word), .bit_start(bit_start),
        .ack_enabled(ack_enabled), .cmd_abort(cmd_abort),
        .ack_sent(ack_sent), .sync_done(sync_done));
    // Any event with no note waiting compares against zero and fails.
    always @(posedge sys_clk) begin
        if (bit_start) saw_bit = 1'b1;
        if (rst_n && (ack_sent || sync_done || cmd_abort)) begin
            e = q.size() ? q.pop_front() : 20'h0;
            `CHK("event", e[18:16], {ack_sent, sync_done, cmd_abort})
            if (e[19]) `CHK("read_word", e[15:0], read_word)
        end
    end
    task automatic send(input logic [4:0] k);
        @(posedge sys_clk);
        cmd_end <= 1'b1;
        {cmd_read, cmd_fw, cmd_go, cmd_ack_on, cmd_ack_off} <= k;
        @(posedge sys_clk);
        cmd_end <= 1'b0;
        {cmd_read, cmd_fw, cmd_go, cmd_ack_on, cmd_ack_off} <= 5'h0;
    endtask
    task automatic strobe(input int gap);
        repeat (gap) @(posedge sys_clk);
        exec_done <= 1'b1;
        @(posedge sys_clk);
        exec_done <= 1'b0;
    endtask
    task automatic settle();
        for (int i = 0; i < 6000 && q.size() > 0; i++) @(posedge sys_clk);
        repeat (500) @(posedge sys_clk);
        `CHK("queue", 0, q.size())
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        void'($urandom(25925));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        `CHK("ack_enabled", 1'b0, ack_enabled)
        q.push_back(ACK);
        send(5'b00010);
        settle();
        `CHK("ack_enabled", 1'b1, ack_enabled)
        for (int n = 0; n < 3; n++) begin
            d = 16'($urandom);
            if (n < 2) q.push_back(ACK | 20'h80000 | d);
            else q.push_back(ABT);
            send(5'b10000);
            for (int i = 0; i < 200 && !bus_req; i++) @(posedge sys_clk);
            `CHK("bus_req", 1'b1, bus_req)
            repeat ($urandom_range(1, 400)) @(posedge sys_clk);
            cpu_wait_stop <= (n == 2);
            bus_ack <= (n < 2);
            bus_rdata <= d;
            @(posedge sys_clk);
            bus_ack <= 1'b0;
            repeat (2) @(posedge sys_clk);
            cpu_wait_stop <= 1'b0;
            settle();
        end
        q.push_back(ACK);
        send(5'b00000);
        strobe($urandom_range(10, 900));
        settle();
        q.push_back(ABT);
        q.push_back(SYN);
        send(5'b00100);
        dlh_host_model_inst.low_pulse(130);
        strobe(1);
        settle();
        q.push_back(ABT);
        send(5'b00000);
        dlh_host_model_inst.low_pulse(6);
        settle();
        saw_bit = 1'b0;
        dlh_host_model_inst.low_pulse(2);
        repeat (20) @(posedge sys_clk);
        `CHK("bit_start", 1'b1, saw_bit)
        repeat (600) @(posedge sys_clk);
        send(5'b01000);
        dlh_host_model_inst.low_pulse(6);
        strobe(20);
        settle();
        send(5'b00001);
        settle();
        `CHK("ack_enabled", 1'b0, ack_enabled)
        send(5'b00000);
        strobe(50);
        settle();
        close_out();
    end
endmodule
